// file: logic/fps_consts.svh
// timing counts, command codes and address constants for the flash protection host
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH

// clock and rounding helpers
`define FPS_CLK_NS          20
`define FPS_MIN_CYC(ns)     ((((ns) + `FPS_CLK_NS - 1) / `FPS_CLK_NS) < 1 ? 1 : (((ns) + `FPS_CLK_NS - 1) / `FPS_CLK_NS))

// bus cycle times in ns
`define FPS_T_AS_NS         20
`define FPS_T_WP_NS         35
`define FPS_T_WPH_NS        30
`define FPS_T_ACC_NS        90
`define FPS_T_AS_CYC        `FPS_MIN_CYC(`FPS_T_AS_NS)
`define FPS_T_WP_CYC        `FPS_MIN_CYC(`FPS_T_WP_NS)
`define FPS_T_WPH_CYC       `FPS_MIN_CYC(`FPS_T_WPH_NS)
`define FPS_T_ACC_CYC       `FPS_MIN_CYC(`FPS_T_ACC_NS)
`define FPS_SYNC_CYC        2

// reset pin times in ns, power-up and protect pulse in us
`define FPS_T_RP_NS         500
`define FPS_T_READY_NS      20000
`define FPS_T_RP_CYC        `FPS_MIN_CYC(`FPS_T_RP_NS)
`define FPS_T_READY_CYC     `FPS_MIN_CYC(`FPS_T_READY_NS)
`define FPS_POWERUP_US      100
`define FPS_PROTECT_US      150
`define FPS_POLL_LIMIT      50000000

// command cycles (word mode)
`define FPS_UNLOCK1_ADDR    21'h000555
`define FPS_UNLOCK2_ADDR    21'h0002aa
`define FPS_UNLOCK1_DATA    16'h00aa
`define FPS_UNLOCK2_DATA    16'h0055
`define FPS_CMD_PROGRAM     16'h00a0
`define FPS_CMD_ERASE_SETUP 16'h0080
`define FPS_CMD_SECT_ERASE  16'h0030
`define FPS_CMD_SEC_ENTER   16'h0088
`define FPS_CMD_SEC_EXIT1   16'h0090
`define FPS_CMD_SEC_EXIT2   16'h0000
`define FPS_CMD_AUTOSELECT  16'h0090
`define FPS_CMD_RESET       16'h00f0
`define FPS_CMD_PROT_SETUP  16'h0060
`define FPS_CMD_PROT_VERIFY 16'h0040
`define FPS_IND_ADDR        21'h000003
`define FPS_PROT_ADDR_BITS  21'h000002
`define FPS_IND_BIT         7
`define FPS_POLL_BIT        7
`define FPS_PROT_OK_BIT     0

// secure sector and serial number windows (word addresses)
`define FPS_SEC_WORDS       21'h008000
`define FPS_SEC_BASE_BOT    21'h000000
`define FPS_SEC_BASE_TOP    21'h1f8000
`define FPS_SN_BASE_BOT     21'h000000
`define FPS_SN_BASE_TOP     21'h1f8000
`define FPS_SN_WORDS        4'h8
// two outermost 8 Kbyte boot sectors, in words
`define FPS_BOOT2_WORDS     21'h002000
`define FPS_BOOT2_BASE_TOP  21'h1fe000

`endif

// file: logic/fps_pkg.sv
// types shared by the flash protection host modules
package fps_pkg;
    typedef enum logic [3:0] {
        OP_READ, OP_PROGRAM, OP_ERASE, OP_SEC_ENTER, OP_SEC_EXIT, OP_READ_IND,
        OP_SEC_LOCK, OP_READ_SN, OP_HW_RESET, OP_TEMP_ON, OP_TEMP_OFF
    } fps_op_e;

    typedef enum logic [2:0] {K_WR, K_RD, K_POLL, K_WAIT, K_RST, K_END} fps_kind_e;

    typedef struct packed {
        fps_op_e     op;
        logic [20:0] addr;
        logic [15:0] data;
    } fps_cmd_s;

    typedef struct packed {
        fps_kind_e   kind;
        logic [20:0] addr;
        logic [15:0] data;
    } fps_step_s;

    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [20:0] addr;
        logic [15:0] dq_o;
        logic        dq_oe;
    } fps_pins_s;
endpackage

// file: logic/fps_cycle.sv
// one asynchronous flash bus cycle, write or read, with synchronised read data
`timescale 1ns/1ps
`include "fps_consts.svh"
module fps_cycle (
    input  wire logic            clk_sys_i,
    input  wire logic            nrst_i,
    input  wire logic            start_i,
    input  wire logic            abort_i,
    input  wire logic            write_i,
    input  wire logic [20:0]     addr_i,
    input  wire logic [15:0]     wdata_i,
    input  wire logic [15:0]     dq_i,
    output fps_pkg::fps_pins_s   pins_o,
    output logic [15:0]          rdata_o,
    output logic                 done_o
);
    typedef enum {P_IDLE, P_SETUP, P_STROBE, P_HOLD} fps_phase_e;
    fps_phase_e  phase;
    logic [7:0]  cnt;
    logic        wr;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;

    // strobe length: reads wait for access time plus the two sync stages
    wire logic [7:0] strobe_len = wr ? 8'(`FPS_T_WP_CYC) : 8'(`FPS_T_ACC_CYC + `FPS_SYNC_CYC);
    wire logic       cnt_end    = (cnt == 8'h01);

    // read data crosses in from the pins
    always_ff @(posedge clk_sys_i) begin
        dq_s1 <= dq_i;
        dq_s2 <= dq_s1;
    end

    // oe_n stays high for the whole write, so only ce_n and we_n low start it
    always_ff @(posedge clk_sys_i) begin
        done_o <= 1'b0;
        if (!nrst_i || abort_i) begin
            phase  <= P_IDLE;
            cnt    <= 8'h00;
            wr     <= 1'b0;
            pins_o <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 21'h000000, dq_o: 16'h0000, dq_oe: 1'b0};
            rdata_o <= 16'h0000;
        end else begin
            case (phase)
                P_IDLE: if (start_i) begin
                    wr          <= write_i;
                    pins_o.addr <= addr_i;
                    pins_o.dq_o <= wdata_i;
                    pins_o.dq_oe <= write_i;
                    pins_o.ce_n <= 1'b0;
                    cnt         <= 8'(`FPS_T_AS_CYC);
                    phase       <= P_SETUP;
                end
                P_SETUP: if (cnt_end) begin
                    pins_o.we_n <= ~wr;
                    pins_o.oe_n <= wr;
                    cnt         <= strobe_len;
                    phase       <= P_STROBE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                P_STROBE: if (cnt_end) begin
                    // command is latched on the we_n rising edge
                    pins_o.we_n <= 1'b1;
                    pins_o.oe_n <= 1'b1;
                    if (!wr) rdata_o <= dq_s2;
                    cnt         <= 8'(`FPS_T_WPH_CYC);
                    phase       <= P_HOLD;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                P_HOLD: if (cnt_end) begin
                    pins_o.ce_n  <= 1'b1;
                    pins_o.dq_oe <= 1'b0;
                    done_o       <= 1'b1;
                    phase        <= P_IDLE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                default: phase <= P_IDLE;
            endcase
        end
    end
endmodule // fps_cycle

// file: logic/fps_host.sv
// host controller driving a parallel nor flash: secure sector, protection and write inhibit handling
//
// Overview of operation
// - host raises reset pin to high program voltage to enter temporary unprotect.
// - lock uses three-cycle enter sequence then in-system protect algorithm.
// - after lock and verify, host writes exit sequence before main array access.
// - write cycle only with chip-select and write strobe low, output enable high.
`timescale 1ns/1ps
`include "fps_consts.svh"
module fps_host #(
    parameter bit          TOP_BOOT       = 1'b0,
    parameter int unsigned POWERUP_CYC    = `FPS_POWERUP_US * 1000 / `FPS_CLK_NS,
    parameter int unsigned PROTECT_CYC    = `FPS_PROTECT_US * 1000 / `FPS_CLK_NS,
    parameter int unsigned POLL_LIMIT     = `FPS_POLL_LIMIT
) (
    input  wire logic               clk_sys_i,
    input  wire logic               nrst_i,
    input  wire logic               cmd_valid_i,
    input  fps_pkg::fps_cmd_s       cmd_i,
    input  wire logic               wp_enable_i,
    input  wire logic               vcc_ok_i,
    input  wire logic [15:0]        dq_i,
    output logic                    cmd_ready_o,
    output logic                    done_o,
    output logic                    err_o,
    output logic [15:0]             rdata_o,
    output logic                    secure_mode_o,
    output logic                    lock_ind_o,
    output logic                    ind_valid_o,
    output logic                    locked_o,
    output logic                    temp_unprotect_o,
    output fps_pkg::fps_pins_s      pins_o,
    output logic                    reset_pin_n_o,
    output logic                    hv_req_o,
    output logic                    protect_accel_pin_o
);
    typedef enum {S_RST_LO, S_WAIT, S_IDLE, S_STEP, S_BUS} fps_state_e;

    // one step of each command sequence, unlock cycles first except for array reads, serial reads and hardware reset
    function automatic fps_pkg::fps_step_s seq_step(input fps_pkg::fps_op_e op, input logic [3:0] idx,
                                                    input logic [20:0] a, input logic [15:0] d,
                                                    input logic [20:0] sn_base);
        fps_pkg::fps_step_s s;
        s = '{kind: fps_pkg::K_END, addr: 21'h000000, data: 16'h0000};
        if (op inside {fps_pkg::OP_PROGRAM, fps_pkg::OP_ERASE, fps_pkg::OP_SEC_ENTER, fps_pkg::OP_SEC_EXIT,
                       fps_pkg::OP_READ_IND, fps_pkg::OP_SEC_LOCK} && idx < 4'h2) begin
            s.kind = fps_pkg::K_WR;
            s.addr = idx[0] ? `FPS_UNLOCK2_ADDR : `FPS_UNLOCK1_ADDR;
            s.data = idx[0] ? `FPS_UNLOCK2_DATA : `FPS_UNLOCK1_DATA;
            return s;
        end
        case (op)
            fps_pkg::OP_READ:     if (idx == 4'h0) s = '{fps_pkg::K_RD, a, 16'h0000};
            fps_pkg::OP_READ_SN:  if (idx == 4'h0) s = '{fps_pkg::K_RD, sn_base + {18'h00000, a[2:0]}, 16'h0000};
            fps_pkg::OP_PROGRAM:
                case (idx)
                    4'h2:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_CMD_PROGRAM};
                    4'h3:    s = '{fps_pkg::K_WR, a, d};
                    4'h4:    s = '{fps_pkg::K_POLL, a, d};
                    default: s = s;
                endcase
            fps_pkg::OP_ERASE:
                case (idx)
                    4'h2:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_CMD_ERASE_SETUP};
                    4'h3:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_UNLOCK1_DATA};
                    4'h4:    s = '{fps_pkg::K_WR, `FPS_UNLOCK2_ADDR, `FPS_UNLOCK2_DATA};
                    4'h5:    s = '{fps_pkg::K_WR, a, `FPS_CMD_SECT_ERASE};
                    4'h6:    s = '{fps_pkg::K_POLL, a, 16'hffff};
                    default: s = s;
                endcase
            fps_pkg::OP_SEC_ENTER: if (idx == 4'h2) s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_CMD_SEC_ENTER};
            fps_pkg::OP_SEC_EXIT:
                case (idx)
                    4'h2:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_CMD_SEC_EXIT1};
                    4'h3:    s = '{fps_pkg::K_WR, 21'h000000, `FPS_CMD_SEC_EXIT2};
                    default: s = s;
                endcase
            fps_pkg::OP_READ_IND:
                case (idx)
                    4'h2:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_CMD_AUTOSELECT};
                    4'h3:    s = '{fps_pkg::K_RD, `FPS_IND_ADDR, 16'h0000};
                    4'h4:    s = '{fps_pkg::K_WR, 21'h000000, `FPS_CMD_RESET};
                    default: s = s;
                endcase
            fps_pkg::OP_SEC_LOCK:
                case (idx)
                    4'h2:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_CMD_SEC_ENTER};
                    4'h3:    s = '{fps_pkg::K_WR, a | `FPS_PROT_ADDR_BITS, `FPS_CMD_PROT_SETUP};
                    4'h4:    s = '{fps_pkg::K_WR, a | `FPS_PROT_ADDR_BITS, `FPS_CMD_PROT_SETUP};
                    4'h5:    s = '{fps_pkg::K_WAIT, a, 16'h0000};
                    4'h6:    s = '{fps_pkg::K_WR, a | `FPS_PROT_ADDR_BITS, `FPS_CMD_PROT_VERIFY};
                    4'h7:    s = '{fps_pkg::K_RD, a | `FPS_PROT_ADDR_BITS, 16'h0000};
                    4'h8:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_UNLOCK1_DATA};
                    4'h9:    s = '{fps_pkg::K_WR, `FPS_UNLOCK2_ADDR, `FPS_UNLOCK2_DATA};
                    4'ha:    s = '{fps_pkg::K_WR, `FPS_UNLOCK1_ADDR, `FPS_CMD_SEC_EXIT1};
                    4'hb:    s = '{fps_pkg::K_WR, 21'h000000, `FPS_CMD_SEC_EXIT2};
                    default: s = s;
                endcase
            fps_pkg::OP_HW_RESET: if (idx == 4'h0) s = '{fps_pkg::K_RST, 21'h000000, 16'h0000};
            default: s = s;
        endcase
        return s;
    endfunction

    fps_state_e         state;
    fps_pkg::fps_cmd_s  cur;
    logic [3:0]         idx;
    logic [31:0]        cnt;
    logic [31:0]        lim;
    logic [31:0]        polls;
    logic               vcc_s1;
    logic               vcc_s2;
    logic               cyc_start;
    logic               cyc_write;
    logic [20:0]        cyc_addr;
    logic [15:0]        cyc_wdata;
    logic [15:0]        cyc_rdata;
    logic               cyc_done;

    // address windows depend on boot configuration
    wire logic [20:0] sec_base  = TOP_BOOT ? `FPS_SEC_BASE_TOP : `FPS_SEC_BASE_BOT;
    wire logic [20:0] sn_base   = TOP_BOOT ? `FPS_SN_BASE_TOP : `FPS_SN_BASE_BOT;
    wire logic        in_sec    = (cmd_i.addr >= sec_base) && (cmd_i.addr - sec_base < `FPS_SEC_WORDS);
    wire logic        in_boot2  = TOP_BOOT ? (cmd_i.addr >= `FPS_BOOT2_BASE_TOP)
                                           : (cmd_i.addr < `FPS_BOOT2_WORDS);
    wire logic        is_modify = cmd_i.op inside {fps_pkg::OP_PROGRAM, fps_pkg::OP_ERASE};
    wire fps_pkg::fps_step_s step = seq_step(cur.op, idx, cur.addr, cur.data, sn_base);

    // refusals checked once, when the command is offered
    wire logic refuse_sec  = is_modify && secure_mode_o && (locked_o || (ind_valid_o && lock_ind_o) || !in_sec);
    wire logic refuse_boot = is_modify && !secure_mode_o && !wp_enable_i && in_boot2 == 1'b0 ? 1'b0
                           : is_modify && !secure_mode_o && wp_enable_i && in_boot2;
    wire logic refuse_rst  = (cmd_i.op == fps_pkg::OP_HW_RESET) && hv_req_o;  // reset pin busy at high voltage
    wire logic refuse_sn   = (cmd_i.op == fps_pkg::OP_READ_SN) && !secure_mode_o;
    wire logic refuse      = !vcc_s2 || refuse_sec || refuse_boot || refuse_rst || refuse_sn;
    wire logic take        = (state == S_IDLE) && cmd_valid_i;
    wire logic poll_match  = (cyc_rdata[`FPS_POLL_BIT] == cur.data[`FPS_POLL_BIT]);

    // supply-good pin from the outside world
    always_ff @(posedge clk_sys_i) begin
        vcc_s1 <= vcc_ok_i;
        vcc_s2 <= vcc_s1;
    end

    // protect pin low means write protect of outer boot sectors; never driven to accelerate voltage
    always_ff @(posedge clk_sys_i) begin
        protect_accel_pin_o <= nrst_i ? ~wp_enable_i : 1'b0;
    end

    fps_cycle u_cycle (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .start_i   (cyc_start),
        .abort_i   (!vcc_s2 && state != S_RST_LO),
        .write_i   (cyc_write),
        .addr_i    (cyc_addr),
        .wdata_i   (cyc_wdata),
        .dq_i      (dq_i),
        .pins_o    (pins_o),
        .rdata_o   (cyc_rdata),
        .done_o    (cyc_done)
    );

    // sequencer: one step at a time, counters for reset, protect pulse and polling
    always_ff @(posedge clk_sys_i) begin
        done_o    <= 1'b0;
        cyc_start <= 1'b0;
        if (!nrst_i) begin
            state <= S_RST_LO;  // strobes idle, reset pin low through power-up
            cnt <= 32'h00000000; lim <= POWERUP_CYC; polls <= 32'h00000000;
            idx <= 4'h0; cur <= '0;
            cyc_write <= 1'b0; cyc_addr <= 21'h000000; cyc_wdata <= 16'h0000;
            cmd_ready_o <= 1'b0; err_o <= 1'b0; rdata_o <= 16'h0000;
            secure_mode_o <= 1'b0; lock_ind_o <= 1'b0; ind_valid_o <= 1'b0; locked_o <= 1'b0;
            temp_unprotect_o <= 1'b0; reset_pin_n_o <= 1'b0; hv_req_o <= 1'b0;
        end else if (!vcc_s2 && state != S_RST_LO && state != S_WAIT) begin
            // lockout: abandon the sequence, treat as power loss
            state <= S_IDLE; cmd_ready_o <= 1'b1;
            secure_mode_o <= 1'b0; hv_req_o <= 1'b0; temp_unprotect_o <= 1'b0;
            // a command offered during lockout is refused with an answer, never left hanging
            if (state != S_IDLE || take) begin done_o <= 1'b1; err_o <= 1'b1; end
        end else begin
            case (state)
                S_RST_LO: if (cnt + 32'h1 >= lim) begin
                    reset_pin_n_o <= 1'b1;
                    secure_mode_o <= 1'b0;
                    cnt <= 32'h0; lim <= `FPS_T_READY_CYC; state <= S_WAIT;
                end else cnt <= cnt + 32'h1;
                S_WAIT: if (cnt + 32'h1 >= lim) begin
                    cnt <= 32'h0;
                    if (cur.op == fps_pkg::OP_SEC_LOCK && idx != 4'h0) begin idx <= idx + 4'h1; state <= S_STEP; end
                    else begin state <= S_IDLE; cmd_ready_o <= 1'b1; done_o <= (cur.op == fps_pkg::OP_HW_RESET); end
                end else cnt <= cnt + 32'h1;
                S_IDLE: if (take) begin
                    cmd_ready_o <= 1'b0; cur <= cmd_i; idx <= 4'h0; polls <= 32'h0; err_o <= 1'b0;
                    if (refuse) begin
                        done_o <= 1'b1; err_o <= 1'b1; cmd_ready_o <= 1'b1;
                    end else if (cmd_i.op == fps_pkg::OP_TEMP_ON || cmd_i.op == fps_pkg::OP_TEMP_OFF) begin
                        // only the pin level moves; stored protection untouched
                        hv_req_o <= (cmd_i.op == fps_pkg::OP_TEMP_ON);
                        temp_unprotect_o <= (cmd_i.op == fps_pkg::OP_TEMP_ON);
                        done_o <= 1'b1; cmd_ready_o <= 1'b1;
                    end else state <= S_STEP;
                end
                S_STEP: case (step.kind)
                    fps_pkg::K_WR, fps_pkg::K_RD, fps_pkg::K_POLL: begin
                        cyc_start <= 1'b1; cyc_write <= (step.kind == fps_pkg::K_WR);
                        cyc_addr <= step.addr; cyc_wdata <= step.data; state <= S_BUS;
                    end
                    fps_pkg::K_WAIT: begin cnt <= 32'h0; lim <= PROTECT_CYC; state <= S_WAIT; end
                    fps_pkg::K_RST: begin
                        reset_pin_n_o <= 1'b0; cnt <= 32'h0; lim <= `FPS_T_RP_CYC; state <= S_RST_LO;
                    end
                    default: begin
                        state <= S_IDLE; cmd_ready_o <= 1'b1; done_o <= 1'b1;
                        if (cur.op == fps_pkg::OP_SEC_ENTER) secure_mode_o <= 1'b1;
                        if (cur.op == fps_pkg::OP_SEC_EXIT || cur.op == fps_pkg::OP_SEC_LOCK) secure_mode_o <= 1'b0;
                    end
                endcase
                S_BUS: if (cyc_done) begin
                    state <= S_STEP; idx <= idx + 4'h1;
                    if (step.kind != fps_pkg::K_WR) rdata_o <= cyc_rdata;
                    if (cur.op == fps_pkg::OP_READ_IND && step.kind == fps_pkg::K_RD) begin
                        lock_ind_o <= cyc_rdata[`FPS_IND_BIT]; ind_valid_o <= 1'b1;
                    end
                    if (cur.op == fps_pkg::OP_SEC_LOCK && step.kind == fps_pkg::K_RD) begin
                        locked_o <= cyc_rdata[`FPS_PROT_OK_BIT];
                        if (!cyc_rdata[`FPS_PROT_OK_BIT]) err_o <= 1'b1;
                    end
                    if (step.kind == fps_pkg::K_POLL && !poll_match) begin
                        if (polls + 32'h1 >= POLL_LIMIT) err_o <= 1'b1;
                        else begin polls <= polls + 32'h1; idx <= idx; end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // fps_host

// file: verif/fps_host_assertions.sv
// port checker for the flash protection host
`timescale 1ns/1ps
module fps_host_assertions #(parameter bit TOP_BOOT = 1'b0) (
    input wire logic          clk_sys_i,
    input wire logic          nrst_i,
    input wire logic          cmd_valid_i,
    input wire logic          cmd_ready_o,
    input fps_pkg::fps_cmd_s  cmd_i,
    input wire logic          wp_enable_i,
    input wire logic          vcc_ok_i,
    input wire logic          done_o,
    input wire logic          err_o,
    input wire logic          secure_mode_o,
    input wire logic          temp_unprotect_o,
    input wire logic          reset_pin_n_o,
    input wire logic          hv_req_o,
    input wire logic          protect_accel_pin_o,
    input fps_pkg::fps_pins_s pins_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // take strobe and outer boot decode; vcc low also refuses, so the refusal checks tie only done, err and ce_n
    wire take    = cmd_ready_o && cmd_valid_i;
    wire in_boot = TOP_BOOT ? cmd_i.addr >= 21'h1fe000 : cmd_i.addr < 21'h002000;
    wire wr_op   = cmd_i.op == fps_pkg::OP_PROGRAM || cmd_i.op == fps_pkg::OP_ERASE;
    a_strobe_qual: assert property (!pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n && pins_o.dq_oe)
        else $error("write strobe without select");
    a_write_hold: assert property ($rose(pins_o.we_n) |-> !pins_o.ce_n && $stable(pins_o.addr))
        else $error("write cycle ends early");
    a_lowvcc_idle: assert property (!vcc_ok_i [*5] |-> pins_o.we_n && !secure_mode_o)
        else $error("write during lockout");
    a_reset_pins: assert property ($rose(nrst_i) |-> !reset_pin_n_o && pins_o.ce_n && pins_o.we_n)
        else $error("pins active in reset");
    a_hv_pin: assert property (hv_req_o |-> reset_pin_n_o && temp_unprotect_o)
        else $error("high voltage with reset low");
    a_wp_follow: assert property ($changed(wp_enable_i) |=> protect_accel_pin_o == !$past(wp_enable_i))
        else $error("protect pin lags");
    a_boot_refuse: assert property (take && wr_op && wp_enable_i && !secure_mode_o && in_boot
        |=> done_o && err_o && pins_o.ce_n)
        else $error("boot sector not refused");
    a_sn_refuse: assert property (take && cmd_i.op == fps_pkg::OP_READ_SN && !secure_mode_o |=> done_o && err_o)
        else $error("serial read outside secure mode");
endmodule // fps_host_assertions

// file: verif/fps_flash_model.sv
// behavioural nor flash answering the host
`timescale 1ns/1ps
module fps_flash_model #(parameter bit FACTORY = 1'b0) (
    input fps_pkg::fps_pins_s pins_i,
    input wire logic          reset_pin_n_i,
    input wire logic          vcc_ok_i,
    output logic [15:0]       dq_o
);
    logic [15:0] mem [logic [21:0]];
    logic [15:0] rd, q = 16'h0;
    logic [1:0]  ul = 2'd0;
    logic        sec = 0, auto = 0, prg = 0, ers = 0, vfy = 0, lk = FACTORY;
    wire [21:0]  key = {sec, pins_i.addr};
    wire [15:0]  w   = pins_i.dq_o;
    initial for (int i = 0; i < 8; i++) mem[{1'b1, 21'(i)}] = 16'hc0d0 + 16'(i);
    // reset pin or lockout drops back to array reads
    always @(negedge reset_pin_n_i or negedge vcc_ok_i) {ul, sec, auto, prg, ers, vfy} = '0;
    // commands latch at the strobe rising edge only; ignored while held in reset
    always @(posedge pins_i.we_n) if (!pins_i.ce_n && pins_i.oe_n && vcc_ok_i && reset_pin_n_i) begin
        vfy = 1'b0;
        if (prg || (ers && ul == 2)) begin
            if (!(sec && lk)) mem[key] = prg ? w : 16'hffff;
            {ul, prg, ers} = '0;
        end else if (ul == 2) {ul, sec, auto, prg, ers} = {2'd0, sec | w == 16'h0088, w == 16'h0090,
            w == 16'h00a0, w == 16'h0080};
        else if (w == 16'h00aa && pins_i.addr == 21'h000555) ul = 2'd1;
        else if (w == 16'h0055 && ul == 1) ul = 2'd2;
        else begin
            lk  = lk | (sec && w == 16'h0060);
            vfy = w == 16'h0040;
            sec = sec && !(auto && w == 16'h0000);
            {ul, auto} = '0;
        end
    end
    // a released bus shows the inverse of the last word, not a stale copy
    always @(pins_i or sec or auto or vfy or lk) begin
        rd = auto ? {8'h00, pins_i.addr == 21'h3 && FACTORY, 7'h00} : vfy ? {15'h0, lk}
            : mem.exists(key) ? mem[key] : 16'hffff;
        if (!pins_i.ce_n && !pins_i.oe_n) q = rd;
        dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? rd : ~q;
    end
endmodule // fps_flash_model

// file: verif/testbench.sv
// self-checking bench for the flash protection host
`timescale 1ns/1ps
module testbench;
    logic clk_sys_i = 0, nrst_i = 0, cmd_valid_i = 0, wp_enable_i = 0, vcc_ok_i = 1;
    fps_pkg::fps_cmd_s  cmd_i = '0;
    fps_pkg::fps_pins_s pins;
    logic [15:0] dq, rdata;
    logic done, err, ready, sec, ind, ind_v, locked, temp, rpin, hv, wp_pin;
    int n_fail = 0, checked = 0, cyc = 0;
    fps_host #(.POWERUP_CYC(20), .PROTECT_CYC(20), .POLL_LIMIT(50)) uut (.clk_sys_i, .nrst_i, .cmd_valid_i,
        .cmd_i, .wp_enable_i, .vcc_ok_i, .dq_i(dq), .cmd_ready_o(ready), .done_o(done), .err_o(err),
        .rdata_o(rdata), .secure_mode_o(sec), .lock_ind_o(ind), .ind_valid_o(ind_v), .locked_o(locked),
        .temp_unprotect_o(temp), .pins_o(pins), .reset_pin_n_o(rpin), .hv_req_o(hv), .protect_accel_pin_o(wp_pin));
    fps_flash_model flash (.pins_i(pins), .reset_pin_n_i(rpin), .vcc_ok_i, .dq_o(dq));
    always #10 clk_sys_i = ~clk_sys_i;
    // hang guard, about ten times the expected run
    always @(posedge clk_sys_i) if (++cyc == 30000) begin n_fail++; print_verdict(); end
    task automatic chk(input string nm, input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin n_fail++; $display("BAD %s exp %h got %h", nm, exp, got); end
    endtask
    // offer one command at a falling edge and wait for its done pulse
    task automatic run(input fps_pkg::fps_op_e op, input logic [20:0] a, input logic [15:0] d = 16'h0);
        // one edge apart, so valid never falls and rises in one time step
        @(negedge clk_sys_i);
        while (ready !== 1'b1) @(negedge clk_sys_i);
        cmd_i = '{op, a, d};
        cmd_valid_i = 1'b1;
        @(negedge clk_sys_i);
        cmd_valid_i = 1'b0;
        // refusals answer on the take edge itself, so look before waiting
        while (done !== 1'b1) @(negedge clk_sys_i);
    endtask
    task automatic t_boot;
        run(fps_pkg::OP_READ_IND, 21'h0);
        chk("ind", {ind_v, ind}, 2'b10);
        wp_enable_i = 1'b1;
        run(fps_pkg::OP_PROGRAM, 21'h001fff, 16'h1234);
        chk("boot_err", {wp_pin, err}, 2'b01);
        run(fps_pkg::OP_TEMP_ON, 21'h0);
        run(fps_pkg::OP_ERASE, 21'h000000);
        chk("temp_boot", {hv, err}, 2'b11);
        run(fps_pkg::OP_TEMP_OFF, 21'h0);
        wp_enable_i = 1'b0;
        run(fps_pkg::OP_PROGRAM, 21'h002000, 16'h00c3);
        run(fps_pkg::OP_READ, 21'h002000);
        chk("prog_data", rdata, 16'h00c3);
        run(fps_pkg::OP_ERASE, 21'h002000);
        run(fps_pkg::OP_READ, 21'h002000);
        chk("erase_data", {err, rdata}, 16'hffff);
    endtask
    task automatic t_secure;
        run(fps_pkg::OP_READ_SN, 21'h5);
        chk("sn_refused", err, 1'b1);
        run(fps_pkg::OP_SEC_ENTER, 21'h0);
        run(fps_pkg::OP_READ_SN, 21'h5);
        chk("sn_word", rdata, 16'hc0d5);
        run(fps_pkg::OP_PROGRAM, 21'h008000, 16'h0001);
        chk("outside_sec", {sec, err}, 2'b11);
        run(fps_pkg::OP_HW_RESET, 21'h0);
        run(fps_pkg::OP_READ, 21'h0);
        chk("reset_exit", {sec, err, rdata[13:0]}, {2'b00, 14'h3fff});
    endtask
    task automatic t_lock;
        run(fps_pkg::OP_SEC_ENTER, 21'h0);
        run(fps_pkg::OP_PROGRAM, 21'h000010, 16'h0055);
        run(fps_pkg::OP_SEC_LOCK, 21'h0);
        chk("locked", {locked, sec, err}, 3'b100);
        run(fps_pkg::OP_SEC_ENTER, 21'h0);
        run(fps_pkg::OP_PROGRAM, 21'h000010, 16'h00aa);
        chk("lock_refuse", err, 1'b1);
        run(fps_pkg::OP_READ, 21'h000010);
        chk("lock_data", rdata, 16'h0055);
        run(fps_pkg::OP_SEC_EXIT, 21'h0);
        chk("exit", sec, 1'b0);
    endtask
    task automatic t_lockout;
        vcc_ok_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        run(fps_pkg::OP_PROGRAM, 21'h004000, 16'h0011);
        chk("lowvcc_err", err, 1'b1);
        vcc_ok_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask
    task automatic print_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        t_boot();
        t_secure();
        t_lock();
        t_lockout();
        print_verdict();
    end
endmodule // testbench
bind fps_host fps_host_assertions #(.TOP_BOOT(TOP_BOOT)) chk_i (.clk_sys_i, .nrst_i, .cmd_valid_i, .cmd_ready_o,
    .cmd_i, .wp_enable_i, .vcc_ok_i, .done_o, .err_o, .secure_mode_o, .temp_unprotect_o, .reset_pin_n_o,
    .hv_req_o, .protect_accel_pin_o, .pins_o);
